// *** hw/dssd_top.sv ***
// Drive status signal detection: frequency, current and fault status outputs.
// Assumes measurements and fault pulses come from logic on pclk, and an APB master.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1: Raise hardware-fault output on internal circuit failure or wiring mistake faults.
// RL2: Hardware-fault sources: brake transistor, earth fault, phase loss, storage, processor, inrush.
// RL3: Earth fault reported as acceleration overcurrent still raises hardware-fault.
// RL4: Codes 91/191, 1/101, 4/104, 12/112 select signals; high code inverts.
// RL5: At-speed when output frequency within programmable percent band of set frequency.
// RL6: Frequency reached when output frequency at or above forward detection frequency.
// RL7: Reverse uses its own detection frequency unless it holds the sentinel.
// RL8: At-speed and frequency-reached forced off during DC injection braking.
// RL9: Frequency comparisons use the output frequency before slip compensation.
// RL10: Overcurrent threshold is a percentage of rated current, default 150.
// RL11: Overcurrent detect after current above threshold while running beyond the delay.
// RL12: Overcurrent detect stays on for the retention time.
// RL13: Retention sentinel holds overcurrent detect until the next start command.
// RL14: Trip select 1 trips and reports overcurrent fault when detection asserts.
// RL15: Trip select 0 keeps operating while overcurrent detect is on.
// RL16: After a trip, detect holds for retention, or until reset with sentinel.
// RL17: Trip select set while detect on causes no trip until detect drops.
// RL18: Zero-current threshold is a percentage of rated current, default 5.
// RL19: Zero-current detect after current below threshold for the programmed time.
// RL20: Zero-current detect holds on for about 0.1 s minimum.
// RL21: Codes 13 and 113 select zero-current detect.
// RL22: Zero-current level of 0 disables zero-current detection.
// RL23: Codes 0 to 99 conduct when active; 100 to 199 conduct when inactive.
// RL24: All times counted in control ticks derived from pclk.
// RL25: Percent thresholds scaled against rated current or set frequency.
module dssd_top #(
  parameter int unsigned TICK_LEN = dssd_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dssd_pkg::dssd_meas_s meas,
  input wire dssd_pkg::dssd_fault_s faults,
  output dssd_pkg::dssd_flags_s flags,
  output logic overcurrent_detect_trip,
  output logic [2:0] term_out
);
  import dssd_pkg::*;

  logic [7:0] at_speed_band;
  logic [15:0] fwd_detect_freq;
  logic [15:0] rev_detect_freq;
  logic [7:0] overcurrent_level;
  logic [15:0] overcurrent_delay;
  logic [7:0] zero_current_level;
  logic [15:0] zero_current_time;
  logic [15:0] overcurrent_retention;
  logic overcurrent_trip_select;
  logic [7:0] terminal_func_sel_a;
  logic [7:0] terminal_func_sel_b;
  logic [7:0] terminal_func_sel_c;
  logic [15:0] rated_current;

  logic [31:0] tick_cnt;
  logic tick;
  logic [15:0] oc_dly_cnt;
  logic [15:0] oc_ret_cnt;
  logic [15:0] zc_dly_cnt;
  logic [15:0] zc_hold_cnt;
  logic start_d;
  logic start_rise;
  logic oc_over;
  logic zc_under;
  logic oc_set;
  logic [15:0] freq_thr;
  logic [15:0] freq_diff;
  logic hw_fault_event;
  logic [4:0] func_vec;
  logic access;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // Percentage of a base value, result saturated to 16 bits
  function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [7:0] pct);
    logic [23:0] prod;
    logic [23:0] quo;
    prod = base * pct;
    quo = prod / 24'd100;
    pct_of = (quo > 24'h00ffff) ? 16'hffff : quo[15:0];
  endfunction

  // Codes 100 to 199 invert; unassigned codes stay off
  function automatic logic term_level(input logic [7:0] code, input logic [4:0] fv);
    logic [7:0] base;
    logic neg;
    neg = (code >= NEG_OFS) && (code <= CODE_NEG_MAX);
    base = neg ? code - NEG_OFS : code;
    term_level = 1'b0;
    if (base == CODE_HW_FAULT) begin
      term_level = fv[0] ^ neg;
    end else if (base == CODE_AT_SPEED) begin
      term_level = fv[1] ^ neg;
    end else if (base == CODE_FREQ_REACHED) begin
      term_level = fv[2] ^ neg;
    end else if (base == CODE_OVERCURRENT) begin
      term_level = fv[3] ^ neg;
    end else if (base == CODE_ZERO_CURRENT) begin
      term_level = fv[4] ^ neg;
    end
  endfunction

  // Control tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (clk_en) begin
      if (tick_cnt >= TICK_LEN - 1) begin
        tick_cnt <= 32'h0000_0000;
        tick <= 1'b1; // RL24
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
        tick <= 1'b0;
      end
    end
  end

  // APB slave: one wait state, registered read data
  assign access = psel && penable;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == OFS_AT_SPEED_BAND) begin
      next_prdata = 32'(at_speed_band);
    end else if (paddr == OFS_FWD_DETECT_FREQ) begin
      next_prdata = 32'(fwd_detect_freq);
    end else if (paddr == OFS_REV_DETECT_FREQ) begin
      next_prdata = 32'(rev_detect_freq);
    end else if (paddr == OFS_OVERCURRENT_LEVEL) begin
      next_prdata = 32'(overcurrent_level);
    end else if (paddr == OFS_OVERCURRENT_DELAY) begin
      next_prdata = 32'(overcurrent_delay);
    end else if (paddr == OFS_ZERO_CURRENT_LEVEL) begin
      next_prdata = 32'(zero_current_level);
    end else if (paddr == OFS_ZERO_CURRENT_TIME) begin
      next_prdata = 32'(zero_current_time);
    end else if (paddr == OFS_OVERCURRENT_RETENTION) begin
      next_prdata = 32'(overcurrent_retention);
    end else if (paddr == OFS_OVERCURRENT_TRIP_SELECT) begin
      next_prdata = 32'(overcurrent_trip_select);
    end else if (paddr == OFS_TERMINAL_FUNC_SEL) begin
      next_prdata = {8'h00, terminal_func_sel_c, terminal_func_sel_b, terminal_func_sel_a};
    end else if (paddr == OFS_RATED_CURRENT) begin
      next_prdata = 32'(rated_current);
    end else if (paddr == OFS_STATUS) begin
      next_prdata = {26'h0000000, overcurrent_detect_trip, flags.zero_current_detect_out,
        flags.overcurrent_detect_out, flags.freq_reached_flag, flags.at_speed_flag, flags.hw_fault_out};
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= access && !pready;
      pslverr <= access && !pready && next_pslverr;
      if (access && !pready && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Configuration registers, written at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      at_speed_band <= RST_AT_SPEED_BAND;
      fwd_detect_freq <= RST_FWD_DETECT_FREQ;
      rev_detect_freq <= RST_REV_DETECT_FREQ;
      overcurrent_level <= RST_OVERCURRENT_LEVEL;
      overcurrent_delay <= RST_OVERCURRENT_DELAY;
      zero_current_level <= RST_ZERO_CURRENT_LEVEL;
      zero_current_time <= RST_ZERO_CURRENT_TIME;
      overcurrent_retention <= RST_OVERCURRENT_RETENTION;
      overcurrent_trip_select <= RST_OVERCURRENT_TRIP_SELECT;
      terminal_func_sel_a <= RST_TERM_SEL_A;
      terminal_func_sel_b <= RST_TERM_SEL_B;
      terminal_func_sel_c <= RST_TERM_SEL_C;
      rated_current <= RST_RATED_CURRENT;
    end else if (clk_en && access && pready && pwrite) begin
      if (paddr == OFS_AT_SPEED_BAND) begin
        at_speed_band <= pwdata[7:0];
      end else if (paddr == OFS_FWD_DETECT_FREQ) begin
        fwd_detect_freq <= pwdata[15:0];
      end else if (paddr == OFS_REV_DETECT_FREQ) begin
        rev_detect_freq <= pwdata[15:0];
      end else if (paddr == OFS_OVERCURRENT_LEVEL) begin
        overcurrent_level <= pwdata[7:0];
      end else if (paddr == OFS_OVERCURRENT_DELAY) begin
        overcurrent_delay <= pwdata[15:0];
      end else if (paddr == OFS_ZERO_CURRENT_LEVEL) begin
        zero_current_level <= pwdata[7:0];
      end else if (paddr == OFS_ZERO_CURRENT_TIME) begin
        zero_current_time <= pwdata[15:0];
      end else if (paddr == OFS_OVERCURRENT_RETENTION) begin
        overcurrent_retention <= pwdata[15:0];
      end else if (paddr == OFS_OVERCURRENT_TRIP_SELECT) begin
        overcurrent_trip_select <= pwdata[0];
      end else if (paddr == OFS_TERMINAL_FUNC_SEL) begin
        terminal_func_sel_a <= pwdata[7:0];
        terminal_func_sel_b <= pwdata[15:8];
        terminal_func_sel_c <= pwdata[23:16];
      end else if (paddr == OFS_RATED_CURRENT) begin
        rated_current <= pwdata[15:0];
      end
    end
  end

  // Hardware fault sources
  assign hw_fault_event = faults.brake_transistor_alarm | faults.earth_fault_at_start // RL2
    | (faults.accel_overcurrent_trip & faults.accel_oc_is_earth_fault) // RL3
    | faults.output_phase_loss | faults.param_storage_fault
    | faults.processor_fault | faults.inrush_limit_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.hw_fault_out <= 1'b0;
    end else if (clk_en) begin
      if (hw_fault_event) begin
        flags.hw_fault_out <= 1'b1; // RL1
      end else if (meas.drive_reset) begin
        flags.hw_fault_out <= 1'b0;
      end
    end
  end

  // Frequency detection on pre-slip output frequency
  assign freq_thr = (meas.reverse && rev_detect_freq != SENTINEL) ? rev_detect_freq // RL7
    : fwd_detect_freq;
  assign freq_diff = (meas.out_freq_pre_slip >= meas.set_freq) // RL9
    ? meas.out_freq_pre_slip - meas.set_freq
    : meas.set_freq - meas.out_freq_pre_slip;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.at_speed_flag <= 1'b0;
      flags.freq_reached_flag <= 1'b0;
    end else if (clk_en) begin
      if (meas.dc_brake) begin
        flags.at_speed_flag <= 1'b0; // RL8
        flags.freq_reached_flag <= 1'b0; // RL8
      end else begin
        flags.at_speed_flag <= freq_diff <= pct_of(meas.set_freq, at_speed_band); // RL5 RL25
        flags.freq_reached_flag <= meas.out_freq_pre_slip >= freq_thr; // RL6
      end
    end
  end

  // Start edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d <= 1'b0;
    end else if (clk_en) begin
      start_d <= meas.start_cmd;
    end
  end
  assign start_rise = meas.start_cmd && !start_d;

  // Overcurrent detection
  assign oc_over = meas.running && (meas.out_current > pct_of(rated_current, overcurrent_level)); // RL10 RL25
  assign oc_set = oc_over && tick && (oc_dly_cnt >= overcurrent_delay) && !flags.overcurrent_detect_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_dly_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (!oc_over) begin
        oc_dly_cnt <= 16'h0000;
      end else if (tick && oc_dly_cnt != 16'hffff) begin
        oc_dly_cnt <= oc_dly_cnt + 16'h0001; // RL11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.overcurrent_detect_out <= 1'b0;
      oc_ret_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (oc_set) begin
        flags.overcurrent_detect_out <= 1'b1; // RL11
        oc_ret_cnt <= 16'h0000;
      end else if (flags.overcurrent_detect_out) begin
        if (overcurrent_retention == SENTINEL) begin
          if (overcurrent_detect_trip ? meas.drive_reset : start_rise) begin
            flags.overcurrent_detect_out <= 1'b0; // RL13 RL16
          end
        end else if (tick) begin
          if (oc_ret_cnt + 16'h0001 >= overcurrent_retention) begin
            flags.overcurrent_detect_out <= 1'b0; // RL12 RL16
          end else begin
            oc_ret_cnt <= oc_ret_cnt + 16'h0001;
          end
        end
      end
    end
  end

  // Trip only at the assertion edge, so a late select change waits for the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overcurrent_detect_trip <= 1'b0;
    end else if (clk_en) begin
      if (oc_set && overcurrent_trip_select) begin
        overcurrent_detect_trip <= 1'b1; // RL14 RL17
      end else if (meas.drive_reset) begin
        overcurrent_detect_trip <= 1'b0; // RL15
      end
    end
  end

  // Zero-current detection
  assign zc_under = meas.running && (zero_current_level != 8'h00) // RL22
    && (meas.out_current < pct_of(rated_current, zero_current_level)); // RL18 RL25

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_dly_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (!zc_under) begin
        zc_dly_cnt <= 16'h0000;
      end else if (tick && zc_dly_cnt != 16'hffff) begin
        zc_dly_cnt <= zc_dly_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags.zero_current_detect_out <= 1'b0;
      zc_hold_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (!flags.zero_current_detect_out) begin
        if (zc_under && tick && zc_dly_cnt >= zero_current_time) begin
          flags.zero_current_detect_out <= 1'b1; // RL19
          zc_hold_cnt <= 16'h0000;
        end
      end else if (tick) begin
        if (zc_hold_cnt < ZC_MIN_HOLD_TICKS) begin
          zc_hold_cnt <= zc_hold_cnt + 16'h0001; // RL20
        end else if (!zc_under) begin
          flags.zero_current_detect_out <= 1'b0;
        end
      end
    end
  end

  // Terminal outputs
  assign func_vec = {flags.zero_current_detect_out, flags.overcurrent_detect_out,
    flags.freq_reached_flag, flags.at_speed_flag, flags.hw_fault_out};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_out <= 3'b000;
    end else if (clk_en) begin
      term_out[0] <= term_level(terminal_func_sel_a, func_vec); // RL4 RL21 RL23
      term_out[1] <= term_level(terminal_func_sel_b, func_vec); // RL4 RL21 RL23
      term_out[2] <= term_level(terminal_func_sel_c, func_vec); // RL4 RL21 RL23
    end
  end

endmodule

`default_nettype wire

// *** include/dssd_pkg.sv ***
// Package for the drive status signal detection block.
// Assumes a 125 MHz pclk and APB register access with 32-bit data.
package dssd_pkg;

  // Clock and control tick timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int unsigned ZC_MIN_HOLD_MS = 100;
  localparam logic [15:0] ZC_MIN_HOLD_TICKS = 16'(ZC_MIN_HOLD_MS / TICK_MS);

  // Register byte offsets
  localparam logic [7:0] OFS_AT_SPEED_BAND = 8'h00;
  localparam logic [7:0] OFS_FWD_DETECT_FREQ = 8'h04;
  localparam logic [7:0] OFS_REV_DETECT_FREQ = 8'h08;
  localparam logic [7:0] OFS_OVERCURRENT_LEVEL = 8'h0c;
  localparam logic [7:0] OFS_OVERCURRENT_DELAY = 8'h10;
  localparam logic [7:0] OFS_ZERO_CURRENT_LEVEL = 8'h14;
  localparam logic [7:0] OFS_ZERO_CURRENT_TIME = 8'h18;
  localparam logic [7:0] OFS_OVERCURRENT_RETENTION = 8'h1c;
  localparam logic [7:0] OFS_OVERCURRENT_TRIP_SELECT = 8'h20;
  localparam logic [7:0] OFS_TERMINAL_FUNC_SEL = 8'h24;
  localparam logic [7:0] OFS_RATED_CURRENT = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;

  // Reset values; frequencies in 0.1 Hz, times in 10 ms ticks, levels in percent
  localparam logic [7:0] RST_AT_SPEED_BAND = 8'h0a;
  localparam logic [15:0] RST_FWD_DETECT_FREQ = 16'h003c;
  localparam logic [15:0] RST_REV_DETECT_FREQ = 16'h270f;
  localparam logic [7:0] RST_OVERCURRENT_LEVEL = 8'h96;
  localparam logic [15:0] RST_OVERCURRENT_DELAY = 16'h0000;
  localparam logic [7:0] RST_ZERO_CURRENT_LEVEL = 8'h05;
  localparam logic [15:0] RST_ZERO_CURRENT_TIME = 16'h0032;
  localparam logic [15:0] RST_OVERCURRENT_RETENTION = 16'h000a;
  localparam logic RST_OVERCURRENT_TRIP_SELECT = 1'b0;
  localparam logic [7:0] RST_TERM_SEL_A = 8'h01;
  localparam logic [7:0] RST_TERM_SEL_B = 8'h04;
  localparam logic [7:0] RST_TERM_SEL_C = 8'h5b;
  localparam logic [15:0] RST_RATED_CURRENT = 16'h03e8;

  // Sentinel for "same as forward" and "hold until start"
  localparam logic [15:0] SENTINEL = 16'h270f;

  // Terminal function codes, positive polarity; negative adds NEG_OFS
  localparam logic [7:0] CODE_AT_SPEED = 8'h01;
  localparam logic [7:0] CODE_FREQ_REACHED = 8'h04;
  localparam logic [7:0] CODE_OVERCURRENT = 8'h0c;
  localparam logic [7:0] CODE_ZERO_CURRENT = 8'h0d;
  localparam logic [7:0] CODE_HW_FAULT = 8'h5b;
  localparam logic [7:0] NEG_OFS = 8'h64;
  localparam logic [7:0] CODE_NEG_MAX = 8'hc7;

  // Status register bit positions
  localparam int unsigned ST_HW_FAULT = 0;
  localparam int unsigned ST_AT_SPEED = 1;
  localparam int unsigned ST_FREQ_REACHED = 2;
  localparam int unsigned ST_OVERCURRENT = 3;
  localparam int unsigned ST_ZERO_CURRENT = 4;
  localparam int unsigned ST_OC_TRIP = 5;

  // Drive measurements and state, same clock domain
  typedef struct packed {
    logic [15:0] out_freq_pre_slip;
    logic [15:0] set_freq;
    logic [15:0] out_current;
    logic running;
    logic start_cmd;
    logic dc_brake;
    logic reverse;
    logic drive_reset;
  } dssd_meas_s;

  // Fault event pulses
  typedef struct packed {
    logic brake_transistor_alarm;
    logic earth_fault_at_start;
    logic accel_overcurrent_trip;
    logic accel_oc_is_earth_fault;
    logic output_phase_loss;
    logic param_storage_fault;
    logic processor_fault;
    logic inrush_limit_fault;
  } dssd_fault_s;

  // Detection flags
  typedef struct packed {
    logic hw_fault_out;
    logic at_speed_flag;
    logic freq_reached_flag;
    logic overcurrent_detect_out;
    logic zero_current_detect_out;
  } dssd_flags_s;

endpackage

// *** test/drive_status_signal_detection_test.sv ***
// Testbench for the status detection block over APB.
// Assumes dssd_top, dssd_term_monitor and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module drive_status_signal_detection_test;
  import dssd_pkg::*;
  localparam int unsigned TL = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv, overcurrent_detect_trip;
  logic neg_a = 1'b0;
  logic [2:0] term_out, term_seen;
  dssd_meas_s meas = '0;
  dssd_fault_s faults = '0;
  dssd_flags_s flags;
  logic [5:0] st;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] rst_tab [12] = '{32'h0a, 32'h3c, 32'h270f, 32'h96, 32'h0, 32'h05, 32'h32, 32'h0a, 32'h0,
    32'h5b0401, 32'h3e8, 32'h2};
  logic [7:0] fpat [8] = '{8'h80, 8'h40, 8'h30, 8'h08, 8'h04, 8'h02, 8'h01, 8'h20};
  logic [0:7] fexp = 8'hfe;
  assign st = {flags, overcurrent_detect_trip};

  dssd_top #(.TICK_LEN(TL)) dssd_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .faults(faults), .flags(flags),
    .overcurrent_detect_trip(overcurrent_detect_trip), .term_out(term_out));
  dssd_term_monitor dssd_term_monitor_inst (.pclk(pclk), .presetn(presetn), .term_out(term_out),
    .term_seen(term_seen));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) begin
        chk("apb wait", 32'h0, 32'h1);
        tally_and_finish;
      end
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic await(input string what, input int b, input logic v, input int lim);
    int k;
    k = 0;
    while (st[b] !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
    chk(what, st[b], v);
    if (st[b] !== v) begin
      tally_and_finish;
    end
  endtask
  task automatic fcase(input logic [15:0] f, input logic rv, input logic dc, input logic eas, input logic efr);
    @(posedge pclk);
    meas.out_freq_pre_slip <= f;
    meas.reverse <= rv;
    meas.dc_brake <= dc;
    step(4);
    chk("at speed", flags.at_speed_flag, eas);
    chk("freq reached", flags.freq_reached_flag, efr);
    chk("terminals", term_seen[1:0], {efr, eas ^ neg_a});
  endtask
  task automatic pulse_reset;
    @(posedge pclk);
    meas.drive_reset <= 1'b1;
    @(posedge pclk);
    meas.drive_reset <= 1'b0;
  endtask

  initial begin
    forever #4 pclk = ~pclk;
  end

  initial begin
    step(20);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rdv, rst_tab[i]);
    end
    apb(1'b1, 8'h30, 32'h1);
    chk("unmapped write err", errv, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped read data", {rdv[31:1], errv}, 32'h1);
    $display("test registers done");
    meas.set_freq <= 16'd500;
    fcase(16'd480, 1'b0, 1'b0, 1'b1, 1'b1);
    fcase(16'd400, 1'b0, 1'b0, 1'b0, 1'b1);
    fcase(16'd60, 1'b0, 1'b0, 1'b0, 1'b1);
    fcase(16'd59, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, OFS_REV_DETECT_FREQ, 32'd100);
    fcase(16'd80, 1'b1, 1'b0, 1'b0, 1'b0);
    fcase(16'd100, 1'b1, 1'b0, 1'b0, 1'b1);
    apb(1'b1, OFS_REV_DETECT_FREQ, 32'h270f);
    fcase(16'd60, 1'b1, 1'b0, 1'b0, 1'b1);
    fcase(16'd480, 1'b0, 1'b1, 1'b0, 1'b0);
    apb(1'b1, OFS_TERMINAL_FUNC_SEL, 32'h5b0465);
    neg_a = 1'b1;
    fcase(16'd400, 1'b0, 1'b0, 1'b0, 1'b1);
    clk_en <= 1'b0;
    fcase(16'd480, 1'b0, 1'b0, 1'b0, 1'b1);
    clk_en <= 1'b1;
    $display("test frequency done");
    foreach (fpat[i]) begin
      @(posedge pclk);
      faults <= fpat[i];
      @(posedge pclk);
      faults <= '0;
      step(4);
      chk("hw fault", flags.hw_fault_out, fexp[i]);
      chk("hw terminal", term_seen[2], fexp[i]);
      pulse_reset();
    end
    $display("test faults done");
    apb(1'b1, OFS_TERMINAL_FUNC_SEL, 32'hbf710c);
    meas.running <= 1'b1;
    meas.out_current <= 16'd1500;
    step(5 * TL);
    chk("oc at level", flags.overcurrent_detect_out, 32'h0);
    meas.out_current <= 16'd1501;
    await("oc on", 2, 1'b1, 3 * TL);
    step(4);
    chk("oc no trip", overcurrent_detect_trip, 32'h0);
    chk("oc terminal", term_seen, 3'b111);
    apb(1'b1, OFS_OVERCURRENT_TRIP_SELECT, 32'h1);
    step(TL);
    chk("late select", overcurrent_detect_trip, 32'h0);
    meas.out_current <= 16'd1000;
    step(3 * TL);
    chk("oc retained", flags.overcurrent_detect_out, 32'h1);
    await("oc off", 2, 1'b0, 15 * TL);
    meas.out_current <= 16'd1501;
    await("oc trip", 0, 1'b1, 3 * TL);
    meas.out_current <= 16'd1000;
    await("oc off after trip", 2, 1'b0, 15 * TL);
    chk("trip held", overcurrent_detect_trip, 32'h1);
    pulse_reset();
    step(2);
    chk("trip cleared", overcurrent_detect_trip, 32'h0);
    apb(1'b1, OFS_OVERCURRENT_TRIP_SELECT, 32'h0);
    apb(1'b1, OFS_OVERCURRENT_RETENTION, 32'h270f);
    apb(1'b1, OFS_OVERCURRENT_DELAY, 32'h3);
    meas.out_current <= 16'd1501;
    step(2 * TL);
    chk("oc delayed", flags.overcurrent_detect_out, 32'h0);
    await("oc after delay", 2, 1'b1, 3 * TL);
    meas.out_current <= 16'd1000;
    step(15 * TL);
    chk("oc until start", flags.overcurrent_detect_out, 32'h1);
    meas.start_cmd <= 1'b1;
    await("oc off at start", 2, 1'b0, 3 * TL);
    meas.start_cmd <= 1'b0;
    $display("test overcurrent done");
    apb(1'b1, OFS_ZERO_CURRENT_TIME, 32'h2);
    meas.out_current <= 16'd49;
    await("zc on", 1, 1'b1, 4 * TL);
    step(4);
    chk("zc terminal", term_seen[1], 32'h0);
    meas.out_current <= 16'd1000;
    step(8 * TL);
    chk("zc min hold", flags.zero_current_detect_out, 32'h1);
    await("zc off", 1, 1'b0, 5 * TL);
    apb(1'b1, OFS_ZERO_CURRENT_LEVEL, 32'h0);
    meas.out_current <= 16'd0;
    step(5 * TL);
    chk("zc disabled", flags.zero_current_detect_out, 32'h0);
    $display("test zero current done");
    tally_and_finish;
  end
endmodule

bind dssd_top dssd_top_sva dssd_top_sva_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .meas(meas), .faults(faults), .flags(flags),
  .overcurrent_detect_trip(overcurrent_detect_trip));
`default_nettype wire

// *** test/dssd_term_monitor.sv ***
// Far-side equipment that reads the status terminals.
// Assumes terminals are sampled on pclk; it only observes.
`timescale 1ns/1ps
`default_nettype none
module dssd_term_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] term_out,
  output logic [2:0] term_seen
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_seen <= 3'h0;
    end else begin
      term_seen <= term_out;
    end
  end
endmodule
`default_nettype wire

// *** test/dssd_top_sva.sv ***
// Checker for the status detection block.
// Assumes it is bound onto dssd_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module dssd_top_sva
  import dssd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire dssd_pkg::dssd_meas_s meas,
  input wire dssd_pkg::dssd_fault_s faults,
  input wire dssd_pkg::dssd_flags_s flags,
  input wire logic overcurrent_detect_trip
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic hw_src = faults.brake_transistor_alarm | faults.earth_fault_at_start | faults.output_phase_loss
    | faults.param_storage_fault | faults.processor_fault | faults.inrush_limit_fault
    | (faults.accel_overcurrent_trip & faults.accel_oc_is_earth_fault);

  a_ready_one_wait: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_hw_fault_set: assert property (clk_en && hw_src |=> flags.hw_fault_out)
    else $error("hardware fault output not raised");
  a_hw_fault_hold: assert property (clk_en && flags.hw_fault_out && !meas.drive_reset |=> flags.hw_fault_out)
    else $error("hardware fault output dropped");
  a_brake_flags_off: assert property (clk_en && meas.dc_brake |=> !flags.at_speed_flag && !flags.freq_reached_flag)
    else $error("frequency flags on during braking");
  a_oc_needs_run: assert property ($rose(flags.overcurrent_detect_out) |-> $past(meas.running))
    else $error("overcurrent detect while stopped");
  a_trip_at_oc: assert property ($rose(overcurrent_detect_trip) |-> $rose(flags.overcurrent_detect_out))
    else $error("trip away from detect rise");
  a_trip_hold: assert property (clk_en && overcurrent_detect_trip && !meas.drive_reset |=> overcurrent_detect_trip)
    else $error("trip dropped without reset");
  a_zc_min_hold: assert property ($rose(flags.zero_current_detect_out) |=> flags.zero_current_detect_out[*8])
    else $error("zero current detect too short");

  c_oc_rise: cover property ($rose(flags.overcurrent_detect_out));
  c_trip_rise: cover property ($rose(overcurrent_detect_trip));
  c_zc_rise: cover property ($rose(flags.zero_current_detect_out));
  c_slverr: cover property (pslverr);
endmodule
`default_nettype wire
